// ### ard_pkg.sv
// Package with the constants, codes and carriers of the ALU result destination decoder.
// Functional notes
// - WR set, no literal: write general register.
// - Quick code 001 loads program counter.
// - Quick codes 011, 111 load operand register.
// - Quick code 010 loads shift counter.
// - Quick code 110 loads CPU key register.
// - Memory write drives result on data bus.
// - Started cycle with mode 01XX loads address.
// - Kind 00, mode 0100: special buffer transfer.
// - Special transfer takes two micro steps.
// - Kind 00, mode 111X issues I/O request.
// - Memory destinations load only when cycle starts.
// - Quick codes 100, 111 increment program counter.
// - Counter loads happen at the end of the micro step.
package ard_pkg;

    // Quick destination codes.
    localparam logic [2:0] QD_NONE = 3'h0;
    localparam logic [2:0] QD_PC = 3'h1;
    localparam logic [2:0] QD_SHIFT = 3'h2;
    localparam logic [2:0] QD_OPER = 3'h3;
    localparam logic [2:0] QD_PC_INC = 3'h4;
    localparam logic [2:0] QD_SPARE = 3'h5;
    localparam logic [2:0] QD_KEY = 3'h6;
    localparam logic [2:0] QD_OPER_INC = 3'h7;

    localparam logic [1:0] CYCLE_NONE = 2'h0;
    localparam logic [3:0] MODE_SPECIAL = 4'h4;
    localparam logic [1:0] MODE_ADDR_HI = 2'h1;
    localparam logic [2:0] MODE_IO_HI = 3'h7;
    localparam int MODE_WRITE_BIT = 1;
    localparam int LITERAL_BIT = 1;

    // Register map, byte offsets within the slave.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_OPER = 8'h08;
    localparam logic [7:0] OFS_SHIFT = 8'h0c;
    localparam logic [7:0] OFS_KEY = 8'h10;
    localparam logic [7:0] OFS_MAR = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_GEN_BASE = 8'h40;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'h1;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] SHIFT_RESET = 8'h00;

    typedef enum logic {
        XFER_IDLE = 1'b0,
        XFER_SECOND = 1'b1
    } ard_xfer_t;

    typedef struct packed {
        logic [1:0] bInputSource;
        logic genWrite;
        logic [3:0] regIndex;
        logic [2:0] quickDest;
        logic [1:0] cycleKind;
        logic [3:0] memoryIoMode;
        logic [1:0] ioTimingSel;
        logic [1:0] ioModeRequest;
        logic [3:0] ioTargetField;
    } ard_micro_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] operand;
        logic [7:0] shiftCount;
        logic [15:0] cpuKey;
    } ard_direct_t;

    typedef struct packed {
        logic cycleReq;
        logic [15:0] addr;
        logic [15:0] data;
        logic dataDrive;
        logic bufferLoad;
        logic [15:0] bufferData;
    } ard_mem_t;

    typedef struct packed {
        logic req;
        logic [15:0] data;
        logic [1:0] ioTimingSel;
        logic [1:0] ioModeRequest;
        logic [3:0] ioTargetField;
    } ard_io_t;

endpackage

// ### ard_gen_regs.sv
// Sixteen general registers written from the ALU result.
`timescale 1ns/1ns
module ard_gen_regs (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [3:0] wrIdx,
    input wire logic [15:0] wrData,
    input wire logic [3:0] rdIdxA,
    output logic [15:0] rdDataA,
    input wire logic [3:0] rdIdxB,
    output logic [15:0] rdDataB
);
    typedef struct packed {
        logic [15:0][15:0] word;
    } ard_regs_t;

    ard_regs_t state;
    ard_regs_t next_state;

    always_comb begin
        next_state = state;
        if (wrEn) begin
            next_state.word[wrIdx] = wrData;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdDataA = state.word[rdIdxA];
    assign rdDataB = state.word[rdIdxB];

    reg_write_a: assert property (@(posedge clock) disable iff (!rstn)
        wrEn |=> state.word[$past(wrIdx)] == $past(wrData))
        else $error("General register write lost.");
endmodule

// ### ard_ahb_slave.sv
// AHB-Lite slave front end: captures the address phase and serves the data phase.
`timescale 1ns/1ns
module ard_ahb_slave (
    input wire logic clock,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic wrEn,
    output logic [7:0] regAddr,
    output logic [31:0] wrData,
    input wire logic [31:0] rdData
);
    typedef struct packed {
        logic active;
        logic write;
        logic [7:0] addr;
    } ard_bus_t;

    ard_bus_t state;
    ard_bus_t next_state;

    // Only full-word transfers are decoded; narrower ones complete with no effect.
    always_comb begin
        next_state = state;
        if (hready) begin
            next_state.active = hsel && htrans[1] && (hsize == 3'h2);
            next_state.write = hwrite;
            next_state.addr = {haddr[7:2], 2'h0};
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wrEn = state.active && state.write;
    assign regAddr = state.addr;
    assign wrData = hwdata;
    assign hrdata = (state.active && !state.write) ? rdData : 32'h0000_0000;
endmodule

// ### ard_decode.sv
// ALU result destination decoder: direct registers, memory and I/O hand-off.
`timescale 1ns/1ns
module ard_decode (
    input wire logic clock,
    input wire logic rstn,
    input wire ard_pkg::ard_micro_t micro,
    input wire logic [15:0] aluResult,
    input wire logic memCycleStarted,
    input wire logic memCycleDone,
    input wire logic [3:0] genReadIdx,
    output logic [15:0] genReadData,
    output ard_pkg::ard_direct_t direct,
    output ard_pkg::ard_mem_t mem,
    output ard_pkg::ard_io_t io,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    typedef struct packed {
        ard_pkg::ard_direct_t direct;
        logic [15:0] mar;
        logic [15:0] memData;
        logic memDataDrive;
        ard_pkg::ard_xfer_t xfer;
        logic [15:0] xferData;
        ard_pkg::ard_io_t io;
        logic enable;
    } ard_state_t;

    ard_state_t state;
    ard_state_t next_state;

    logic busWrEn;
    logic [7:0] busAddr;
    logic [31:0] busWrData;
    logic [31:0] busRdData;
    logic [15:0] genBusData;
    logic genWrEn;
    logic isMemCycle;
    logic memWriteStart;
    logic marStart;
    logic specialReq;
    logic specialStart;
    logic ioStart;

    ard_ahb_slave bus (
        .clock(clock),
        .rstn(rstn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .wrEn(busWrEn),
        .regAddr(busAddr),
        .wrData(busWrData),
        .rdData(busRdData)
    );

    // The literal and mask codes reuse the write bit, so it must not fire then.
    assign genWrEn = state.enable && micro.genWrite
        && !micro.bInputSource[ard_pkg::LITERAL_BIT];

    ard_gen_regs regs (
        .clock(clock),
        .rstn(rstn),
        .wrEn(genWrEn),
        .wrIdx(micro.regIndex),
        .wrData(aluResult),
        .rdIdxA(genReadIdx),
        .rdDataA(genReadData),
        .rdIdxB(busAddr[5:2]),
        .rdDataB(genBusData)
    );

    // Indirect memory destinations are decoded here but only act once memory control
    // reports that the cycle really began.
    assign isMemCycle = micro.cycleKind != ard_pkg::CYCLE_NONE;
    assign specialReq = !isMemCycle && micro.memoryIoMode == ard_pkg::MODE_SPECIAL;
    assign memWriteStart = isMemCycle && micro.memoryIoMode[ard_pkg::MODE_WRITE_BIT]
        && memCycleStarted;
    assign marStart = isMemCycle && micro.memoryIoMode[3:2] == ard_pkg::MODE_ADDR_HI
        && memCycleStarted;
    assign specialStart = specialReq && memCycleStarted
        && state.xfer == ard_pkg::XFER_IDLE;
    assign ioStart = !isMemCycle
        && micro.memoryIoMode[3:1] == ard_pkg::MODE_IO_HI;

    always_comb begin
        next_state = state;
        // Direct destinations all land on the edge ending this micro step.
        if (state.enable) begin
            unique case (micro.quickDest)
                ard_pkg::QD_PC: begin
                    next_state.direct.pc = aluResult;
                end
                ard_pkg::QD_SHIFT: begin
                    next_state.direct.shiftCount = aluResult[7:0];
                end
                ard_pkg::QD_OPER: begin
                    next_state.direct.operand = aluResult;
                end
                ard_pkg::QD_PC_INC: begin
                    next_state.direct.pc = state.direct.pc + 16'h0001;
                end
                ard_pkg::QD_KEY: begin
                    next_state.direct.cpuKey = aluResult;
                end
                ard_pkg::QD_OPER_INC: begin
                    next_state.direct.operand = aluResult;
                    next_state.direct.pc = state.direct.pc + 16'h0001;
                end
                ard_pkg::QD_NONE, ard_pkg::QD_SPARE: begin
                    next_state.direct = state.direct;
                end
            endcase
        end
        if (marStart) begin
            next_state.mar = aluResult;
        end
        // A new write start wins over the end of the previous cycle.
        if (memWriteStart) begin
            next_state.memData = aluResult;
            next_state.memDataDrive = 1'b1;
        end else if (memCycleDone) begin
            next_state.memDataDrive = 1'b0;
        end
        unique case (state.xfer)
            ard_pkg::XFER_IDLE: begin
                if (specialStart) begin
                    next_state.xfer = ard_pkg::XFER_SECOND;
                    next_state.xferData = aluResult;
                end
            end
            ard_pkg::XFER_SECOND: begin
                next_state.xfer = ard_pkg::XFER_IDLE;
            end
        endcase
        // The I/O control decides what to do with the fields passed along.
        next_state.io.req = ioStart;
        if (ioStart) begin
            next_state.io.data = aluResult;
            next_state.io.ioTimingSel = micro.ioTimingSel;
            next_state.io.ioModeRequest = micro.ioModeRequest;
            next_state.io.ioTargetField = micro.ioTargetField;
        end
        if (busWrEn && busAddr == ard_pkg::OFS_CTRL) begin
            next_state.enable = busWrData[ard_pkg::CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state.direct.pc <= ard_pkg::WORD_RESET;
            state.direct.operand <= ard_pkg::WORD_RESET;
            state.direct.shiftCount <= ard_pkg::SHIFT_RESET;
            state.direct.cpuKey <= ard_pkg::WORD_RESET;
            state.mar <= ard_pkg::WORD_RESET;
            state.memData <= ard_pkg::WORD_RESET;
            state.memDataDrive <= 1'b0;
            state.xfer <= ard_pkg::XFER_IDLE;
            state.xferData <= ard_pkg::WORD_RESET;
            state.io <= '0;
            state.enable <= ard_pkg::CTRL_ENABLE_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        busRdData = 32'h0000_0000;
        if (busAddr >= ard_pkg::OFS_GEN_BASE) begin
            busRdData = {16'h0000, genBusData};
        end else begin
            unique case (busAddr)
                ard_pkg::OFS_CTRL: busRdData = {31'h0000_0000, state.enable};
                ard_pkg::OFS_PC: busRdData = {16'h0000, state.direct.pc};
                ard_pkg::OFS_OPER: busRdData = {16'h0000, state.direct.operand};
                ard_pkg::OFS_SHIFT: busRdData = {24'h00_0000, state.direct.shiftCount};
                ard_pkg::OFS_KEY: busRdData = {16'h0000, state.direct.cpuKey};
                ard_pkg::OFS_MAR: busRdData = {16'h0000, state.mar};
                ard_pkg::OFS_STATUS: busRdData = {30'h0000_0000, state.memDataDrive,
                    state.xfer};
                default: busRdData = 32'h0000_0000;
            endcase
        end
    end

    assign direct = state.direct;
    assign io = state.io;
    // The request is combinational so memory control can answer in the same step.
    assign mem.cycleReq = isMemCycle || (specialReq && state.xfer == ard_pkg::XFER_IDLE);
    assign mem.addr = state.mar;
    assign mem.data = state.memData;
    assign mem.dataDrive = state.memDataDrive;
    assign mem.bufferLoad = state.xfer == ard_pkg::XFER_SECOND;
    assign mem.bufferData = state.xferData;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    literal_no_write_a: assert property (
        micro.bInputSource[1] |-> !genWrEn)
        else $error("General register written while literal in use.");

    pc_load_a: assert property (
        state.enable && micro.quickDest == 3'h1 |=> direct.pc == $past(aluResult))
        else $error("Program counter not loaded from ALU.");

    operand_load_a: assert property (
        state.enable && (micro.quickDest == 3'h3 || micro.quickDest == 3'h7)
        |=> direct.operand == $past(aluResult))
        else $error("Operand register not loaded from ALU.");

    shift_load_a: assert property (
        state.enable && micro.quickDest == 3'h2
        |=> direct.shiftCount == $past(aluResult[7:0]))
        else $error("Shift counter not loaded from ALU.");

    key_load_a: assert property (
        state.enable && micro.quickDest == 3'h6 |=> direct.cpuKey == $past(aluResult))
        else $error("CPU key not loaded from ALU.");

    pc_increment_a: assert property (
        state.enable && (micro.quickDest == 3'h4 || micro.quickDest == 3'h7)
        |=> direct.pc == $past(direct.pc) + 16'h0001)
        else $error("Program counter not incremented.");

    quiet_codes_a: assert property (
        micro.quickDest == 3'h0 || micro.quickDest == 3'h4 || micro.quickDest == 3'h5
        |=> $stable(direct.operand) && $stable(direct.shiftCount)
            && $stable(direct.cpuKey))
        else $error("Direct register changed on a quiet code.");

    mem_write_data_a: assert property (
        memWriteStart |=> mem.dataDrive && mem.data == $past(aluResult))
        else $error("Write data not driven on memory bus.");

    mar_load_a: assert property (
        marStart |=> mem.addr == $past(aluResult))
        else $error("Memory address register not loaded.");

    no_start_hold_a: assert property (
        !memCycleStarted |=> $stable(mem.addr))
        else $error("Address register changed without a started cycle.");

    special_two_step_a: assert property (
        specialStart |=> mem.bufferLoad && mem.bufferData == $past(aluResult)
        ##1 !mem.bufferLoad)
        else $error("Special transfer did not take two steps.");

    io_request_a: assert property (
        micro.cycleKind == 2'h0 && micro.memoryIoMode[3:1] == 3'h7
        |=> io.req && io.data == $past(aluResult))
        else $error("I/O request not issued.");

    same_edge_a: assert property (
        state.enable && micro.quickDest == 3'h7
        |=> direct.operand == $past(aluResult) && direct.pc != $past(direct.pc))
        else $error("Combined loads split across edges.");
endmodule

// ### ard_mem_io_model.sv
// Behavioural memory control and I/O control sections facing the decoder.
`timescale 1ns/1ns
module ard_mem_io_model (
    input wire logic clock,
    input wire logic rstn,
    input wire ard_pkg::ard_mem_t mem,
    input wire ard_pkg::ard_io_t io,
    input wire logic busy,
    input wire logic [3:0] doneDelay,
    output logic memCycleStarted,
    output logic memCycleDone,
    output logic [15:0] instrBuf,
    output logic [15:0] memInReg,
    output logic [15:0] ioReg
);
    logic [3:0] waitCount;

    // A busy memory refuses the cycle, so no indirect memory destination may load.
    assign memCycleStarted = rstn & mem.cycleReq & ~busy;

    always @(posedge clock) begin
        if (!rstn) begin
            waitCount <= 4'h0;
            memCycleDone <= 1'b0;
            instrBuf <= 16'h0000;
            memInReg <= 16'h0000;
            ioReg <= 16'h0000;
        end else begin
            memCycleDone <= 1'b0;
            if (mem.dataDrive && !memCycleDone) begin
                if (waitCount == doneDelay) begin
                    memCycleDone <= 1'b1;
                    waitCount <= 4'h0;
                end else begin
                    waitCount <= waitCount + 4'h1;
                end
            end
            if (mem.bufferLoad) begin
                instrBuf <= mem.bufferData;
                memInReg <= mem.bufferData;
            end
            // Loads at once; a real I/O control may wait on its own timing field.
            if (io.req) begin
                ioReg <= io.data;
            end
        end
    end
endmodule

// ### alu_result_destination_decode_bench.sv
// Self-checking bench of the ALU result destination decoder.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin mismatches++; \
    $display("ERROR %s expected %h got %h", nm, ex, got); end end
module alu_result_destination_decode_bench;
    logic clock;
    logic rstn;
    ard_pkg::ard_micro_t micro;
    logic [15:0] aluResult;
    logic memCycleStarted;
    logic memCycleDone;
    logic [3:0] genReadIdx;
    logic [15:0] genReadData;
    ard_pkg::ard_direct_t direct;
    ard_pkg::ard_mem_t mem;
    ard_pkg::ard_io_t io;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic busy;
    logic [3:0] doneDelay;
    logic [15:0] instrBuf;
    logic [15:0] memInReg;
    logic [15:0] ioReg;
    logic [15:0] ePc;
    logic [15:0] eOp;
    logic [15:0] eKey;
    logic [7:0] eSh;
    int mismatches;
    int testsRun;
    int cycles;

    ard_decode dut_u (.clock(clock), .rstn(rstn), .micro(micro), .aluResult(aluResult),
        .memCycleStarted(memCycleStarted), .memCycleDone(memCycleDone),
        .genReadIdx(genReadIdx), .genReadData(genReadData), .direct(direct), .mem(mem),
        .io(io), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp));

    ard_mem_io_model partner_u (.clock(clock), .rstn(rstn), .mem(mem), .io(io), .busy(busy),
        .doneDelay(doneDelay), .memCycleStarted(memCycleStarted),
        .memCycleDone(memCycleDone), .instrBuf(instrBuf), .memInReg(memInReg),
        .ioReg(ioReg));

    function automatic ard_pkg::ard_micro_t mk(input logic [1:0] src, input logic gw,
        input logic [3:0] idx, input logic [2:0] qd, input logic [1:0] ck,
        input logic [3:0] md);
        ard_pkg::ard_micro_t m;
        m = '0;
        m.bInputSource = src;
        m.genWrite = gw;
        m.regIndex = idx;
        m.quickDest = qd;
        m.cycleKind = ck;
        m.memoryIoMode = md;
        m.ioTimingSel = 2'h2;
        m.ioModeRequest = 2'h1;
        m.ioTargetField = 4'h9;
        return m;
    endfunction

    // The micro step driven here is sampled by the decoder at the following edge.
    task step(input ard_pkg::ard_micro_t m, input logic [15:0] a);
        @(posedge clock);
        micro <= m;
        aluResult <= a;
    endtask

    task idle;
        step('0, 16'h0000);
        @(negedge clock);
    endtask

    // The wait ends at the first edge with hreadyout high; the slave ties hreadyout to 1.
    task waitReady;
        do begin
            @(posedge clock);
        end while (hreadyout !== 1'b1);
    endtask

    task ahbXfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
        output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        waitReady;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady;
        rd = hrdata;
    endtask

    task checkReg(input string nm, input logic [31:0] a, input logic [31:0] ex);
        logic [31:0] d;
        ahbXfer(a, 1'b0, 32'h0, d);
        `CHK(nm, ex, d)
    endtask

    task checkDirect;
        `CHK("pc", ePc, direct.pc)
        `CHK("operand", eOp, direct.operand)
        `CHK("shiftCount", eSh, direct.shiftCount)
        `CHK("cpuKey", eKey, direct.cpuKey)
    endtask

    task waitDriveDrop;
        int n;
        n = 0;
        while (mem.dataDrive === 1'b1 && n < 12) begin
            @(negedge clock);
            n++;
        end
        `CHK("driveEnded", 1'b0, mem.dataDrive)
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles >= 3000) begin
            mismatches++;
            end_of_test;
        end
    end

    initial begin
        logic [31:0] d;
        logic [15:0] a;
        rstn = 1'b0;
        micro = '0;
        aluResult = 16'h0000;
        genReadIdx = 4'h0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        busy = 1'b0;
        doneDelay = 4'h2;
        {ePc, eOp, eKey, eSh} = '0;
        mismatches = 0;
        testsRun = 0;
        cycles = 0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) checkReg("resetValue", 4 * i, {31'h0, i == 0});
        checkReg("unmapped", 32'h30, 32'h0);
        `CHK("hresp", 1'b0, hresp)
        `CHK("hready", 1'b1, hreadyout)
        $display("test reset done");
        for (int q = 0; q < 8; q++) begin
            a = 16'h1230 + q;
            step(mk(2'h0, 1'b0, 4'h0, q[2:0], 2'h0, 4'h0), a);
            idle;
            if (q == 1) ePc = a;
            if (q == 4 || q == 7) ePc = ePc + 16'h1;
            if (q == 3 || q == 7) eOp = a;
            if (q == 2) eSh = a[7:0];
            if (q == 6) eKey = a;
            checkDirect;
        end
        step(mk(2'h0, 1'b0, 4'h0, 3'h1, 2'h0, 4'h0), 16'h4000);
        step(mk(2'h0, 1'b0, 4'h0, 3'h4, 2'h0, 4'h0), 16'h0055);
        idle;
        ePc = 16'h4001;
        checkDirect;
        checkReg("pcBus", 32'h4, {16'h0, ePc});
        $display("test quick done");
        for (int i = 0; i < 16; i++) step(mk(2'h0, 1'b1, i[3:0], 3'h0, 2'h0, 4'h0), 16'ha500 + i);
        step(mk(2'h2, 1'b1, 4'h3, 3'h0, 2'h0, 4'h0), 16'hffff);
        step(mk(2'h3, 1'b1, 4'h4, 3'h0, 2'h0, 4'h0), 16'hffff);
        idle;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            genReadIdx <= i[3:0];
            @(negedge clock);
            `CHK("genReg", 16'ha500 + i, genReadData)
        end
        checkReg("genBus", 32'h54, 32'h0000a505);
        @(posedge clock);
        genReadIdx <= 4'h2;
        step(mk(2'h0, 1'b1, 4'h2, 3'h7, 2'h0, 4'h0), 16'h7777);
        idle;
        eOp = 16'h7777;
        ePc = ePc + 16'h1;
        checkDirect;
        `CHK("genSameEdge", 16'h7777, genReadData)
        ahbXfer(32'h0, 1'b1, 32'h0, d);
        step(mk(2'h0, 1'b1, 4'h2, 3'h1, 2'h0, 4'h0), 16'hbeef);
        idle;
        checkDirect;
        `CHK("genDisabled", 16'h7777, genReadData)
        ahbXfer(32'h0, 1'b1, 32'h1, d);
        $display("test general done");
        step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h1, 4'h6), 16'h2468);
        idle;
        `CHK("dataDrive", 1'b1, mem.dataDrive)
        `CHK("memData", 16'h2468, mem.data)
        `CHK("memAddr", 16'h2468, mem.addr)
        waitDriveDrop;
        `CHK("driveDropped", 1'b0, mem.dataDrive)
        checkReg("marBus", 32'h14, 32'h00002468);
        @(posedge clock);
        busy <= 1'b1;
        step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h2, 4'h6), 16'h1357);
        idle;
        `CHK("refusedAddr", 16'h2468, mem.addr)
        `CHK("refusedDrive", 1'b0, mem.dataDrive)
        busy <= 1'b0;
        step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h3, 4'h4), 16'h1111);
        idle;
        `CHK("readAddr", 16'h1111, mem.addr)
        `CHK("readDrive", 1'b0, mem.dataDrive)
        step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h1, 4'ha), 16'h2222);
        idle;
        `CHK("writeData", 16'h2222, mem.data)
        `CHK("keptAddr", 16'h1111, mem.addr)
        waitDriveDrop;
        $display("test memory done");
        step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h0, 4'h4), 16'h5a5a);
        step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h0, 4'h4), 16'h6b6b);
        @(negedge clock);
        `CHK("bufferLoad", 1'b1, mem.bufferLoad)
        `CHK("bufferData", 16'h5a5a, mem.bufferData)
        `CHK("reqMasked", 1'b0, mem.cycleReq)
        idle;
        `CHK("bufferEnd", 1'b0, mem.bufferLoad)
        `CHK("instrBuf", 16'h5a5a, instrBuf)
        `CHK("memInReg", 16'h5a5a, memInReg)
        idle;
        `CHK("secondMasked", 1'b0, mem.bufferLoad)
        $display("test special done");
        for (int k = 14; k < 16; k++) begin
            step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h0, k[3:0]), 16'h9000 + k);
            idle;
            `CHK("ioReq", 1'b1, io.req)
            `CHK("ioData", 16'h9000 + k, io.data)
            `CHK("ioFields", 8'h99, {io.ioTimingSel, io.ioModeRequest, io.ioTargetField})
            @(negedge clock);
            `CHK("ioReqEnd", 1'b0, io.req)
            `CHK("ioReg", 16'h9000 + k, ioReg)
        end
        step(mk(2'h0, 1'b0, 4'h0, 3'h0, 2'h1, 4'he), 16'h3333);
        idle;
        `CHK("ioNotForMemory", 1'b0, io.req)
        waitDriveDrop;
        $display("test io done");
        end_of_test;
    end
endmodule
